/* inc/ir_thermo_pkg.sv */
// constants shared by the infrared thermometer serial command port
package ir_thermo_pkg;
    // ****************************************************************
    // serial frame
    // ****************************************************************
    localparam logic [5:0] OP_END = 6'h08;
    localparam logic [5:0] HDR_LAST = 6'h0F;
    localparam logic [5:0] ADDR_END = 6'h10;
    localparam logic [5:0] CMD_LAST = 6'h1F;
    localparam logic [5:0] CMD_END = 6'h20;
    localparam logic [5:0] READ_START = 6'h18;
    localparam logic [5:0] READ_END = 6'h28;
    // ****************************************************************
    // internal register map
    // ****************************************************************
    localparam logic [7:0] OBJ_ADDR = 8'h09;
    localparam logic [7:0] AMB_ADDR = 8'h0A;
    localparam logic [7:0] UNLOCK_ADDR = 8'h10;
    localparam logic [7:0] PUMP_ADDR = 8'h18;
    localparam logic [7:0] THR_ADDR = 8'h20;
    localparam logic [7:0] HYST_ADDR = 8'h21;
    localparam logic [7:0] POL_ADDR = 8'h22;
    localparam logic [15:0] UNLOCK_KEY = 16'hB200;
    localparam logic [15:0] PUMP_KEY = 16'h0065;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ****************************************************************
    // temperature register fields
    // ****************************************************************
    localparam int TEMP_MSB = 15;
    localparam int TEMP_LSB = 4;
    localparam int OVER_BIT = 3;
    localparam int UNDER_BIT = 2;
    localparam int FATAL_BIT = 1;
    localparam logic [11:0] TEMP_FULL = 12'hFFF;
    localparam logic [11:0] TEMP_ZERO = 12'h000;
    // ****************************************************************
    // relay comparator presets (codes over -20..120 degrees)
    // ****************************************************************
    localparam logic [11:0] THR_PRESET = 12'hD24;
    localparam logic [11:0] HYST_PRESET = 12'h092;
    localparam logic POL_INVERTING = 1'b1;
    // ****************************************************************
    // eeprom layout
    // ****************************************************************
    localparam logic [7:0] USER_BASE = 8'h38;
    localparam logic [7:0] EE_CFG_MARK = 8'h30;
    localparam logic [7:0] EE_CFG_THR = 8'h31;
    localparam logic [7:0] EE_CFG_HYST = 8'h32;
    localparam logic [7:0] EE_CFG_POL = 8'h33;
    localparam logic [15:0] CFG_MARK_KEY = 16'h5A01;
    localparam logic [15:0] EE_ERASED = 16'hFFFF;
endpackage

/* rtl/ir_thermo_spi_command_slave.sv */
// serial command slave of an infrared thermometer with eeprom and relay
`timescale 1ns/1ns
`default_nettype none

module ir_thermo_spi_command_slave #(
    parameter int EE_WORDS = 64,
    parameter logic [11:0] THR_DEFAULT = ir_thermo_pkg::THR_PRESET,
    parameter logic [11:0] HYST_DEFAULT = ir_thermo_pkg::HYST_PRESET
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    input wire logic meas_valid_i,
    input wire logic [11:0] object_raw_i,
    input wire logic [11:0] ambient_raw_i,
    input wire logic ambient_over_flag_i,
    input wire logic ambient_under_flag_i,
    input wire logic fatal_eeprom_error_i,
    output logic relay_output_o,
    output logic relay_output_oe_n_o
);
    localparam int EE_AW = $clog2(EE_WORDS);

    // ****************************************************************
    // opcode decoding
    // ****************************************************************
    function automatic logic is_reg_wr(input logic [7:0] op);
        is_reg_wr = (op[6:4] == 3'h5) && !op[2];
    endfunction

    function automatic logic is_reg_rd(input logic [7:0] op);
        is_reg_rd = (op[6:2] == 5'h12);
    endfunction

    function automatic logic is_ee_prog(input logic [7:0] op);
        is_ee_prog = (op[7:4] == 4'h1);
    endfunction

    function automatic logic is_ee_clear(input logic [7:0] op);
        is_ee_clear = (op[7:5] == 3'h1);
    endfunction

    function automatic logic is_ee_fetch(input logic [7:0] op);
        is_ee_fetch = (op[6:3] == 4'h1);
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        is_read = is_reg_rd(op) || is_ee_fetch(op);
    endfunction

    // packs a temperature word; range flags override the measured code
    function automatic logic [15:0] pack_temp(input logic [11:0] t, input logic ov,
                                              input logic un, input logic fe);
        logic [11:0] f;
        f = ov ? ir_thermo_pkg::TEMP_FULL : (un ? ir_thermo_pkg::TEMP_ZERO : t);
        pack_temp = {f, ov, un, fe, 1'b0};
    endfunction

    // ****************************************************************
    // link side, clocked by the master's serial clock
    // ****************************************************************
    logic link_rst;
    logic [5:0] cnt_q;
    logic [31:0] shift_q;
    logic [15:0] hdr_q;
    logic [31:0] cmd_q;
    logic hdr_tgl_q;
    logic cmd_tgl_q;
    logic serial_out_q;
    logic [5:0] rd_idx;
    logic [15:0] rd_data_q;

    // deselect clears the frame, so a short frame never completes
    assign link_rst = chip_select_n_i | ~nrst_i;
    assign rd_idx = 6'(ir_thermo_pkg::READ_END - 6'h01 - cnt_q);

    always_ff @(posedge sclk_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
        end
        else
        begin
            shift_q <= {shift_q[30:0], serial_in_i};
            if (cnt_q != ir_thermo_pkg::READ_END)
            begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // header and command words stay still between toggles for the core
    always_ff @(posedge sclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hdr_q <= 16'h0000;
            cmd_q <= 32'h0000_0000;
            hdr_tgl_q <= 1'b0;
            cmd_tgl_q <= 1'b0;
        end
        else if (!chip_select_n_i)
        begin
            if (cnt_q == ir_thermo_pkg::HDR_LAST)
            begin
                hdr_q <= {shift_q[14:0], serial_in_i};
                hdr_tgl_q <= ~hdr_tgl_q;
            end
            if (cnt_q == ir_thermo_pkg::CMD_LAST)
            begin
                cmd_q <= {shift_q[30:0], serial_in_i};
                cmd_tgl_q <= ~cmd_tgl_q;
            end
        end
    end

    // output changes on the falling edge, so it is valid at the rising one
    always_ff @(negedge sclk_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            serial_out_q <= 1'b0;
        end
        else if (cnt_q >= ir_thermo_pkg::OP_END && cnt_q < ir_thermo_pkg::ADDR_END)
        begin
            serial_out_q <= shift_q[7];
        end
        else if (is_read(hdr_q[15:8]))
        begin
            // rd_data_q was settled by the core several clocks before edge 25
            serial_out_q <= (cnt_q >= ir_thermo_pkg::READ_START &&
                             cnt_q < ir_thermo_pkg::READ_END) ?
                            rd_data_q[rd_idx[3:0]] : 1'b0;
        end
        else
        begin
            serial_out_q <= (cnt_q >= ir_thermo_pkg::ADDR_END &&
                             cnt_q < ir_thermo_pkg::CMD_END) ? shift_q[7] : 1'b0;
        end
    end

    assign serial_out_o = serial_out_q;

    // ****************************************************************
    // crossing into the core clock
    // ****************************************************************
    logic hdr_s1_q;
    logic hdr_s2_q;
    logic hdr_s3_q;
    logic cmd_s1_q;
    logic cmd_s2_q;
    logic cmd_s3_q;
    logic hdr_ev;
    logic cmd_ev;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hdr_s1_q <= 1'b0;
            hdr_s2_q <= 1'b0;
            hdr_s3_q <= 1'b0;
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            cmd_s3_q <= 1'b0;
        end
        else
        begin
            hdr_s1_q <= hdr_tgl_q;
            hdr_s2_q <= hdr_s1_q;
            hdr_s3_q <= hdr_s2_q;
            cmd_s1_q <= cmd_tgl_q;
            cmd_s2_q <= cmd_s1_q;
            cmd_s3_q <= cmd_s2_q;
        end
    end

    assign hdr_ev = hdr_s2_q ^ hdr_s3_q;
    assign cmd_ev = cmd_s2_q ^ cmd_s3_q;

    // ****************************************************************
    // command execution
    // ****************************************************************
    logic [7:0] x_op;
    logic [7:0] x_addr;
    logic [15:0] x_data;
    logic reg_wr_ev;
    logic ee_en;
    logic [15:0] obj_q;
    logic [15:0] amb_q;
    logic [15:0] key_q;
    logic unlocked_q;
    logic [15:0] pump_q;
    logic [11:0] thr_q;
    logic [11:0] hyst_q;
    logic pol_q;
    logic boot_q;
    logic [15:0] ee_mem [EE_WORDS];
    logic [15:0] reg_rd_val;

    assign x_op = cmd_q[31:24];
    assign x_addr = cmd_q[23:16];
    assign x_data = cmd_q[15:0];
    assign reg_wr_ev = cmd_ev && is_reg_wr(x_op);
    // bulk opcodes are never executed: a slip would wipe the calibration
    assign ee_en = cmd_ev && unlocked_q && (pump_q == ir_thermo_pkg::PUMP_KEY);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            key_q <= ir_thermo_pkg::REG_RESET;
            unlocked_q <= 1'b0;
        end
        else if (reg_wr_ev && x_addr == ir_thermo_pkg::UNLOCK_ADDR)
        begin
            key_q <= x_data;
            // stays unlocked until the next power cycle
            unlocked_q <= unlocked_q | (x_data == ir_thermo_pkg::UNLOCK_KEY);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pump_q <= ir_thermo_pkg::REG_RESET;
        end
        else if (reg_wr_ev && x_addr == ir_thermo_pkg::PUMP_ADDR && unlocked_q)
        begin
            pump_q <= x_data;
        end
    end

    // eeprom keeps its content over reset, as a nonvolatile array would
    always_ff @(posedge clk_i)
    begin
        if (ee_en && is_ee_prog(x_op))
        begin
            ee_mem[x_addr[EE_AW-1:0]] <= x_data;
        end
        else if (ee_en && is_ee_clear(x_op))
        begin
            ee_mem[x_addr[EE_AW-1:0]] <= ir_thermo_pkg::EE_ERASED;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            obj_q <= ir_thermo_pkg::REG_RESET;
            amb_q <= ir_thermo_pkg::REG_RESET;
        end
        else if (meas_valid_i && !unlocked_q)
        begin
            obj_q <= pack_temp(object_raw_i, ambient_over_flag_i, ambient_under_flag_i,
                               fatal_eeprom_error_i);
            amb_q <= pack_temp(ambient_raw_i, ambient_over_flag_i, ambient_under_flag_i,
                               fatal_eeprom_error_i);
        end
    end

    // comparator settings: presets, replaced at boot by stored ones when the mark word holds CFG_MARK_KEY
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            boot_q <= 1'b1;
            thr_q <= THR_DEFAULT;
            hyst_q <= HYST_DEFAULT;
            pol_q <= ir_thermo_pkg::POL_INVERTING;
        end
        else
        begin
            boot_q <= 1'b0;
            if (boot_q && ee_mem[ir_thermo_pkg::EE_CFG_MARK[EE_AW-1:0]] ==
                ir_thermo_pkg::CFG_MARK_KEY)
            begin
                thr_q <= ee_mem[ir_thermo_pkg::EE_CFG_THR[EE_AW-1:0]][11:0];
                hyst_q <= ee_mem[ir_thermo_pkg::EE_CFG_HYST[EE_AW-1:0]][11:0];
                pol_q <= ee_mem[ir_thermo_pkg::EE_CFG_POL[EE_AW-1:0]][0];
            end
            else if (reg_wr_ev && x_addr == ir_thermo_pkg::THR_ADDR)
            begin
                thr_q <= x_data[11:0];
            end
            else if (reg_wr_ev && x_addr == ir_thermo_pkg::HYST_ADDR)
            begin
                hyst_q <= x_data[11:0];
            end
            else if (reg_wr_ev && x_addr == ir_thermo_pkg::POL_ADDR)
            begin
                pol_q <= x_data[0];
            end
        end
    end

    always_comb
    begin
        case (hdr_q[7:0])
            ir_thermo_pkg::OBJ_ADDR: reg_rd_val = obj_q;
            ir_thermo_pkg::AMB_ADDR: reg_rd_val = amb_q;
            ir_thermo_pkg::UNLOCK_ADDR: reg_rd_val = key_q;
            ir_thermo_pkg::PUMP_ADDR: reg_rd_val = pump_q;
            ir_thermo_pkg::THR_ADDR: reg_rd_val = {4'h0, thr_q};
            ir_thermo_pkg::HYST_ADDR: reg_rd_val = {4'h0, hyst_q};
            ir_thermo_pkg::POL_ADDR: reg_rd_val = {15'h0000, pol_q};
            default: reg_rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_data_q <= 16'h0000;
        end
        else if (hdr_ev)
        begin
            if (is_reg_rd(hdr_q[15:8]))
            begin
                rd_data_q <= reg_rd_val;
            end
            else if (is_ee_fetch(hdr_q[15:8]))
            begin
                rd_data_q <= ee_mem[hdr_q[EE_AW-1:0]];
            end
            else
            begin
                rd_data_q <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // relay comparator and open-drain driver
    // ****************************************************************
    logic hot_q;
    logic relay_oe_n_q;
    logic relay_out_q;
    logic [11:0] obj_t;

    assign obj_t = obj_q[ir_thermo_pkg::TEMP_MSB:ir_thermo_pkg::TEMP_LSB];

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hot_q <= 1'b0;
            relay_oe_n_q <= 1'b1;
            relay_out_q <= 1'b0;
        end
        else
        begin
            // widened sum so a large hysteresis cannot wrap past full scale
            if (obj_t > thr_q)
            begin
                hot_q <= 1'b1;
            end
            else if ({1'b0, obj_t} + {1'b0, hyst_q} < {1'b0, thr_q})
            begin
                hot_q <= 1'b0;
            end
            relay_oe_n_q <= pol_q ? hot_q : ~hot_q;
            relay_out_q <= 1'b0;
        end
    end

    assign relay_output_o = relay_out_q;
    assign relay_output_oe_n_o = relay_oe_n_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_unlock_wr;
        reg_wr_ev && x_addr == ir_thermo_pkg::UNLOCK_ADDR && x_data == ir_thermo_pkg::UNLOCK_KEY;
    endsequence

    sequence s_pump_wr;
        reg_wr_ev && x_addr == ir_thermo_pkg::PUMP_ADDR;
    endsequence

    a_unlock_key: assert property (s_unlock_wr |=> unlocked_q)
        else $error("unlock key did not unlock");
    a_pump_locked: assert property (s_pump_wr ##0 !unlocked_q |=> $stable(pump_q))
        else $error("pump control changed while locked");
    a_pump_write: assert property (s_pump_wr ##0 unlocked_q |=> pump_q == $past(x_data))
        else $error("pump control write lost");
    a_temp_freeze: assert property (unlocked_q |=> $stable(obj_q) && $stable(amb_q))
        else $error("temperature updated while unlocked");
    a_over_clamp: assert property (
        meas_valid_i && !unlocked_q && ambient_over_flag_i
        |=> amb_q[15:4] == ir_thermo_pkg::TEMP_FULL && amb_q[3] &&
        obj_q[15:4] == ir_thermo_pkg::TEMP_FULL)
        else $error("over range not forced to full scale");
    a_under_clamp: assert property (
        meas_valid_i && !unlocked_q && !ambient_over_flag_i && ambient_under_flag_i
        |=> amb_q[15:4] == ir_thermo_pkg::TEMP_ZERO && amb_q[2])
        else $error("under range not forced to zero");
    a_res_zero: assert property (!obj_q[0] && !amb_q[0])
        else $error("reserved bit set");
    a_ee_program: assert property (
        ee_en && is_ee_prog(x_op)
        |=> ee_mem[$past(x_addr[EE_AW-1:0])] == $past(x_data))
        else $error("eeprom word not programmed");
    a_relay_pol: assert property (
        hot_q && $stable(hot_q) && $stable(pol_q)
        |=> relay_oe_n_q == $past(pol_q))
        else $error("relay polarity wrong");
    a_echo_delay: assert property (
        @(posedge sclk_i) disable iff (link_rst)
        cnt_q >= ir_thermo_pkg::OP_END && cnt_q < ir_thermo_pkg::ADDR_END
        |-> serial_out_q == $past(serial_in_i, 8))
        else $error("opcode echo not eight clocks late");
    a_read_first: assert property (
        @(posedge sclk_i) disable iff (link_rst)
        cnt_q == ir_thermo_pkg::READ_START && is_read(hdr_q[15:8])
        |-> serial_out_q == rd_data_q[15])
        else $error("read data msb not at edge 25");
endmodule

`default_nettype wire

/* verif/spi_master_model.sv */
// serial master model that drives command frames into the port
`timescale 1ns/1ns
`default_nettype none
module spi_master_model
(
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i
);
    // ****
    // frame engine
    // ****
    // opcodes 1001xxxx and 101xxxxx are never sent
    initial
    begin
        sclk_o = 1'b0;
        chip_select_n_o = 1'b1;
        serial_in_o = 1'b1;
    end
    // sclk stands still low between frames; n below 32 aborts the frame
    task automatic xfer(input logic [31:0] word, input int n,
                        output logic [15:0] echo, output logic [15:0] rdat);
        logic [39:0] fr;
        fr = {word, 8'h00};
        echo = 16'h0000;
        rdat = 16'h0000;
        #37;
        chip_select_n_o = 1'b0;
        #80;
        for (int k = 1; k <= n; k++)
        begin
            serial_in_o = fr[40-k];
            #80;
            sclk_o = 1'b1;
            if (k >= 9 && k <= 24)
                echo = {echo[14:0], serial_out_i};
            if (k >= 25)
                rdat = {rdat[14:0], serial_out_i};
            #80;
            sclk_o = 1'b0;
        end
        #80;
        chip_select_n_o = 1'b1;
        // released data line shows the inverse, never a stale level
        serial_in_o = ~serial_in_o;
        #400;
    endtask
endmodule
`default_nettype wire

/* verif/ir_thermo_spi_command_slave_tb.sv */
// self-checking bench for the thermometer serial command port
`timescale 1ns/1ns
`default_nettype none
module ir_thermo_spi_command_slave_tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic mv = 1'b0;
    logic [11:0] obj = 12'h000;
    logic [11:0] amb = 12'h000;
    logic ovf = 1'b0;
    logic unf = 1'b0;
    logic fef = 1'b0;
    logic rly;
    logic rly_oe_n;
    logic [15:0] rdata;
    logic [15:0] cfg [4] = '{16'h5A01, 16'h0100, 16'h0010, 16'h0001};
    int failures = 0;
    int checks_done = 0;

    always #10 clk_i = ~clk_i;

    ir_thermo_spi_command_slave u_ir_thermo_spi_command_slave (
        .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .chip_select_n_i(cs_n),
        .serial_in_i(sdi), .serial_out_o(sdo), .meas_valid_i(mv),
        .object_raw_i(obj), .ambient_raw_i(amb), .ambient_over_flag_i(ovf),
        .ambient_under_flag_i(unf), .fatal_eeprom_error_i(fef),
        .relay_output_o(rly), .relay_output_oe_n_o(rly_oe_n));

    spi_master_model u_spi_master_model (.sclk_o(sclk), .chip_select_n_o(cs_n),
        .serial_in_o(sdi), .serial_out_i(sdo));

    // ****
    // tasks
    // ****
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xf(input logic [7:0] op, input logic [7:0] ad,
                      input logic [15:0] d, input int n);
        logic [15:0] ec;
        u_spi_master_model.xfer({op, ad, d}, n, ec, rdata);
        if (n == 32)
            check(ec, {op, ad});
        if (n == 40)
            check(ec, {op, 8'h00});
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] ad, input logic [15:0] d);
        xf(op, ad, d, 32);
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] ad, input logic [15:0] exp);
        xf(op, ad, 16'h0000, 40);
        check(rdata, exp);
    endtask
    task automatic meas(input logic [11:0] o, input logic [11:0] a, input logic [2:0] f);
        @(negedge clk_i);
        obj = o;
        amb = a;
        {ovf, unf, fef} = f;
        mv = 1'b1;
        @(negedge clk_i);
        mv = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic relay_is(input logic exp);
        check({15'h0000, rly_oe_n}, {15'h0000, exp});
        check({15'h0000, rly}, 16'h0000);
    endtask

    // ****
    // sequence
    // ****
    initial
    begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        meas(12'hABC, 12'h345, 3'b000);
        rd(8'h48, 8'h09, 16'hABC0);
        rd(8'hCB, 8'h0A, 16'h3450);
        meas(12'h100, 12'h123, 3'b001);
        rd(8'h48, 8'h0A, 16'h1232);
        meas(12'h800, 12'h456, 3'b100);
        rd(8'h48, 8'h0A, 16'hFFF8);
        rd(8'h48, 8'h09, 16'hFFF8);
        meas(12'h800, 12'h456, 3'b010);
        rd(8'h48, 8'h09, 16'h0004);
        relay_is(1'b0);
        meas(12'hD25, 12'h345, 3'b000);
        relay_is(1'b1);
        wr(8'hDB, 8'h22, 16'h0000);
        relay_is(1'b0);
        meas(12'hC92, 12'h345, 3'b000);
        relay_is(1'b0);
        meas(12'hC91, 12'h345, 3'b000);
        relay_is(1'b1);
        wr(8'h50, 8'h20, 16'h0123);
        xf(8'h50, 8'h20, 16'h0456, 24);
        rd(8'h48, 8'h20, 16'h0123);
        wr(8'h50, 8'h18, 16'h0065);
        rd(8'h48, 8'h18, 16'h0000);
        wr(8'h50, 8'h10, 16'hB200);
        rd(8'h48, 8'h10, 16'hB200);
        meas(12'h777, 12'h111, 3'b000);
        rd(8'h48, 8'h09, 16'hC910);
        wr(8'h50, 8'h18, 16'h0065);
        rd(8'h48, 8'h18, 16'h0065);
        wr(8'h20, 8'h38, 16'h0000);
        wr(8'h10, 8'h38, 16'hA55A);
        rd(8'h08, 8'h38, 16'hA55A);
        wr(8'h2F, 8'h3F, 16'h0000);
        rd(8'h88, 8'h3F, 16'hFFFF);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h20, 8'h30 + 8'(i), 16'h0000);
            wr(8'h1F, 8'h30 + 8'(i), cfg[i]);
        end
        // power cycle: stored threshold 0x100 must take over from the preset
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rd(8'h48, 8'h20, 16'h0100);
        rd(8'h48, 8'h21, 16'h0010);
        rd(8'h48, 8'h22, 16'h0001);
        meas(12'h101, 12'h345, 3'b000);
        relay_is(1'b1);
        report_and_stop();
    end

    // cuts a hang short well after the expected few hundred microseconds
    initial
    begin
        #1000000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
